// File: spu_pkg.sv
// Purpose: shared constants, types and helpers of the paced serial port
// Assumes: 100 MHz system clock, 16x oversampling of the line
// Notes:   register map and field layout live here
package spu_pkg;

  localparam int unsigned SPU_CLK_HZ      = 100_000_000;
  localparam int unsigned SPU_OVERSAMPLE  = 16;
  localparam int unsigned SPU_BAUD_HZ [8] = '{150, 300, 600, 1200, 2400, 4800, 9600, 19200};

  localparam logic [10:0] SPU_RX_DEPTH    = 11'h7d0;
  localparam logic [10:0] SPU_XOFF_LEVEL  = 11'h790;
  localparam logic [10:0] SPU_XON_LEVEL   = 11'h040;
  localparam logic [7:0]  SPU_XON_CHAR    = 8'h11;
  localparam logic [7:0]  SPU_XOFF_CHAR   = 8'h13;
  localparam logic [3:0]  SPU_MID_TICK    = 4'h7;
  localparam logic [3:0]  SPU_LAST_TICK   = 4'hf;

  localparam logic [1:0]  SPU_ADDR_CFG    = 2'h0;
  localparam logic [1:0]  SPU_ADDR_STATUS = 2'h1;
  localparam logic [1:0]  SPU_ADDR_TXDATA = 2'h2;
  localparam logic [1:0]  SPU_ADDR_RXDATA = 2'h3;

  typedef enum logic [2:0] {
    SPU_PAR_NONE = 3'b000,
    SPU_PAR_ODD  = 3'b001,
    SPU_PAR_EVEN = 3'b010,
    SPU_PAR_ONE  = 3'b011,
    SPU_PAR_ZERO = 3'b100
  } spu_par_t;

  typedef enum logic [1:0] {
    SPU_RX_IDLE  = 2'b00,
    SPU_RX_START = 2'b01,
    SPU_RX_BITS  = 2'b10
  } spu_rx_st_t;

  // cfg word bits 11:0: echo, route_cmd, tx_pace, rx_pace, stop2, data8, parity[2:0], baud[2:0]
  typedef struct packed {
    logic       echo;
    logic       route_cmd;
    logic       tx_pace;
    logic       rx_pace;
    logic       stop2;
    logic       data8;
    spu_par_t   parity;
    logic [2:0] baud;
  } spu_cfg_t;

  typedef struct packed {
    logic        line_err;
    logic        overrun;
    logic        xoff_sent;
    logic        paused;
    logic        tx_full;
    logic [10:0] count;
  } spu_status_t;

  typedef struct packed {
    logic [1:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } spu_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] char;
  } spu_cmd_t;

  typedef struct packed {
    spu_cfg_t    cfg;
    logic        rx_s1;
    logic        rx_s2;
    spu_rx_st_t  rx_st;
    logic [3:0]  rx_tick;
    logic [3:0]  rx_idx;
    logic [10:0] rx_sh;
    logic        tx_line;
    logic [10:0] tx_sh;
    logic [3:0]  tx_left;
    logic [3:0]  tx_tick;
    logic [7:0]  tx_hold;
    logic        tx_full;
    logic        echo_pend;
    logic [7:0]  echo_char;
    logic        paused;
    logic        xoff_sent;
    logic [10:0] wr_ptr;
    logic [10:0] rd_ptr;
    logic [10:0] count;
    logic        mem_we;
    logic [7:0]  mem_wd;
    logic        wr_done;
    logic        overrun;
    logic        line_err;
    logic [15:0] rdata;
    spu_cmd_t    cmd;
  } spu_top_st_t;

  localparam spu_top_st_t SPU_TOP_RST = '{
    cfg:     '{parity: SPU_PAR_NONE, default: '0},
    rx_st:   SPU_RX_IDLE,
    rx_s1:   1'b1,
    rx_s2:   1'b1,
    tx_line: 1'b1,
    default: '0
  };

  function automatic logic spu_par_bit(input spu_par_t mode, input logic [7:0] d);
    unique case (mode)
      SPU_PAR_ODD:  return ~(^d);
      SPU_PAR_EVEN: return ^d;
      SPU_PAR_ONE:  return 1'b1;
      default:      return 1'b0;
    endcase
  endfunction

  function automatic logic [10:0] spu_wrap(input logic [10:0] p);
    return (p == SPU_RX_DEPTH - 11'h001) ? 11'h000 : p + 11'h001;
  endfunction

endpackage

// File: spu_rxmem.sv
// Purpose: receive character store, one write and one registered read port
// Assumes: write and read of the same slot in one cycle returns the old value
// Notes:   caller hides the new word until two cycles after its write
`timescale 1ns/10ps
`default_nettype none
module spu_rxmem
  import spu_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        we,
  input  wire logic [10:0] waddr,
  input  wire logic [7:0]  wdata,
  input  wire logic [10:0] raddr,
  output var  logic [7:0]  rdata
);

  logic [7:0] mem_reg [SPU_RX_DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem_reg[waddr] <= wdata;
    end
    rdata <= mem_reg[raddr];
  end

endmodule
`default_nettype wire

// File: spu_tick.sv
// Purpose: 16x oversampling tick for the selected line rate
// Assumes: CLK_HZ divisible enough that the rounding error stays small
// Notes:   a rate change takes effect at once, the running count being compared with the new divisor
`timescale 1ns/10ps
`default_nettype none
module spu_tick
  import spu_pkg::*;
#(
  parameter int unsigned CLK_HZ = SPU_CLK_HZ
)(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [2:0] sel,
  output var  logic       tick
);

  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } spu_tick_st_t;

  spu_tick_st_t st_reg;
  spu_tick_st_t st_next;
  logic [15:0]  div_tab [8];

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_div
      assign div_tab[gi] = 16'(CLK_HZ / (SPU_BAUD_HZ[gi] * SPU_OVERSAMPLE) - 1);
    end
  endgenerate

  always_comb begin
    st_next      = st_reg;
    st_next.tick = 1'b0;
    if (st_reg.cnt >= div_tab[sel]) begin
      st_next.cnt  = 16'h0000;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;

  a_tick_wrap: assert property (@(posedge clk) disable iff (reset)
    st_reg.cnt >= div_tab[sel] |=> st_reg.tick && st_reg.cnt == 16'h0000)
    else $error("tick counter did not wrap at the selected divisor");

endmodule
`default_nettype wire

// File: spu_top.sv
// Purpose: paced asynchronous serial port with receive store and command route
// Assumes: rxd is asynchronous to clk; register port strobes are one cycle wide
// Notes:   cfg is loaded from the retained copy during reset, never defaulted
// Behaviour
// - The line runs at one of eight rates from 150 to 19200 baud chosen in cfg.
// - Parity is none, odd, even, forced one or forced zero as cfg selects.
// - A character has seven or eight data bits and one or two stop bits per cfg.
// - With transmit pacing on, an XOFF from the far end halts software data until XON.
// - Each pacing direction is on or off by itself, and when off never pauses.
// - Up to 2000 received characters are held until software reads them.
// - Characters routed to the command line are consumed at once, with no pacing.
// - A cfg bit routes received characters to the command line or the store.
// - With echo on, each received character other than an XON or XOFF taken for transmit pacing is sent straight back.
// - Configuration survives reset and changes only by a register write.
`timescale 1ns/10ps
`default_nettype none
module spu_top
  import spu_pkg::*;
#(
  parameter int unsigned CLK_HZ = SPU_CLK_HZ
)(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire spu_req_t    req,
  output var  logic [15:0] rdata,
  input  wire logic        rxd,
  output var  logic        txd,
  input  wire spu_cfg_t    nv_cfg,
  output var  spu_cfg_t    cfg_out,
  output var  spu_cmd_t    cmd
);

  spu_top_st_t st_reg;
  spu_top_st_t st_next;
  logic        tick;
  logic [7:0]  mem_q;
  logic        has_par;
  logic [3:0]  nrx;
  logic [3:0]  ntx;
  logic [10:0] sh_new;
  logic [7:0]  rx_char;
  logic        rx_bad;
  logic        rx_done;
  logic        flow_char;
  logic        want_off;
  logic        want_on;
  logic        tx_go;
  logic        sw_load;
  logic [7:0]  tx_char;
  logic [7:0]  tx_data;
  logic [11:0] frame;
  logic        pop;

  spu_tick #(
    .CLK_HZ (CLK_HZ)
  ) u_tick (
    .clk   (clk),
    .reset (reset),
    .sel   (st_reg.cfg.baud),
    .tick  (tick)
  );

  // read port follows the next pointer so back-to-back pops see fresh data
  spu_rxmem u_mem (
    .clk   (clk),
    .we    (st_reg.mem_we),
    .waddr (st_reg.wr_ptr),
    .wdata (st_reg.mem_wd),
    .raddr (st_next.rd_ptr),
    .rdata (mem_q)
  );

  always_comb begin
    st_next           = st_reg;
    st_next.cmd.valid = 1'b0;
    st_next.rdata     = 16'h0000;
    st_next.mem_we    = 1'b0;
    st_next.wr_done   = st_reg.mem_we;
    st_next.rx_s1     = rxd;
    st_next.rx_s2     = st_reg.rx_s1;
    has_par = st_reg.cfg.parity inside {SPU_PAR_ODD, SPU_PAR_EVEN,
                                        SPU_PAR_ONE, SPU_PAR_ZERO};
    nrx = (st_reg.cfg.data8 ? 4'h8 : 4'h7) + {3'h0, has_par} + 4'h1;
    ntx = nrx + {3'h0, st_reg.cfg.stop2} + 4'h1;
    pop = 1'b0;

    // transmit: pacing characters first, then echo, then software data
    want_off = st_reg.cfg.rx_pace && !st_reg.cfg.route_cmd && !st_reg.xoff_sent
               && st_reg.count >= SPU_XOFF_LEVEL;
    want_on  = st_reg.xoff_sent && (!st_reg.cfg.rx_pace || st_reg.cfg.route_cmd
               || st_reg.count <= SPU_XON_LEVEL);
    tx_go   = 1'b0;
    sw_load = 1'b0;
    tx_char = st_reg.tx_hold;
    if (st_reg.tx_left == 4'h0) begin
      if (want_off || want_on) begin
        tx_go             = 1'b1;
        tx_char           = want_off ? SPU_XOFF_CHAR : SPU_XON_CHAR;
        st_next.xoff_sent = want_off;
      end else if (st_reg.echo_pend) begin
        tx_go             = 1'b1;
        tx_char           = st_reg.echo_char;
        st_next.echo_pend = 1'b0;
      end else if (st_reg.tx_full && !st_reg.paused) begin
        tx_go           = 1'b1;
        sw_load         = 1'b1;
        st_next.tx_full = 1'b0;
      end
    end
    tx_data = st_reg.cfg.data8 ? tx_char : {1'b0, tx_char[6:0]};
    frame    = 12'hfff;
    frame[0] = 1'b0;
    if (st_reg.cfg.data8) begin
      frame[8:1] = tx_char;
    end else begin
      frame[7:1] = tx_char[6:0];
    end
    if (has_par) begin
      frame[st_reg.cfg.data8 ? 9 : 8] = spu_par_bit(st_reg.cfg.parity, tx_data);
    end
    if (tx_go) begin
      st_next.tx_line = 1'b0;
      st_next.tx_sh   = frame[11:1];
      st_next.tx_left = ntx;
      st_next.tx_tick = 4'h0;
    end else if (st_reg.tx_left != 4'h0 && tick) begin
      st_next.tx_tick = st_reg.tx_tick + 4'h1;
      if (st_reg.tx_tick == SPU_LAST_TICK) begin
        if (st_reg.tx_left == 4'h1) begin
          st_next.tx_left = 4'h0;
          st_next.tx_line = 1'b1;
        end else begin
          st_next.tx_line = st_reg.tx_sh[0];
          st_next.tx_sh   = {1'b1, st_reg.tx_sh[10:1]};
          st_next.tx_left = st_reg.tx_left - 4'h1;
        end
      end
    end

    // register port; a full holding register refuses further data
    if (req.wr) begin
      unique case (req.addr)
        SPU_ADDR_CFG:    st_next.cfg = spu_cfg_t'(req.wdata[11:0]);
        SPU_ADDR_TXDATA: begin
          if (!st_reg.tx_full) begin
            st_next.tx_hold = req.wdata[7:0];
            st_next.tx_full = 1'b1;
          end
        end
        SPU_ADDR_STATUS, SPU_ADDR_RXDATA: ;
      endcase
    end
    if (req.rd) begin
      unique case (req.addr)
        SPU_ADDR_CFG:    st_next.rdata = {4'h0, st_reg.cfg};
        SPU_ADDR_STATUS: begin
          st_next.rdata    = {st_reg.line_err, st_reg.overrun, st_reg.xoff_sent,
                              st_reg.paused, st_reg.tx_full, st_reg.count};
          st_next.overrun  = 1'b0;
          st_next.line_err = 1'b0;
        end
        SPU_ADDR_TXDATA: st_next.rdata = {8'h00, st_reg.tx_hold};
        SPU_ADDR_RXDATA: begin
          if (st_reg.count != 11'h000) begin
            pop           = 1'b1;
            st_next.rdata = {8'h00, mem_q};
          end
        end
      endcase
    end

    // receive: sample mid bit at 16x, sets below win over the clears above
    sh_new                = st_reg.rx_sh;
    sh_new[st_reg.rx_idx] = st_reg.rx_s2;
    rx_done               = 1'b0;
    unique case (st_reg.rx_st)
      SPU_RX_IDLE: begin
        if (tick && !st_reg.rx_s2) begin
          st_next.rx_st   = SPU_RX_START;
          st_next.rx_tick = 4'h0;
        end
      end
      SPU_RX_START: begin
        if (tick) begin
          st_next.rx_tick = st_reg.rx_tick + 4'h1;
          if (st_reg.rx_tick == SPU_MID_TICK) begin
            st_next.rx_tick = 4'h0;
            st_next.rx_idx  = 4'h0;
            st_next.rx_st   = st_reg.rx_s2 ? SPU_RX_IDLE : SPU_RX_BITS;
          end
        end
      end
      SPU_RX_BITS: begin
        if (tick) begin
          st_next.rx_tick = st_reg.rx_tick + 4'h1;
          if (st_reg.rx_tick == SPU_LAST_TICK) begin
            st_next.rx_sh = sh_new;
            if (st_reg.rx_idx == nrx - 4'h1) begin
              rx_done       = 1'b1;
              st_next.rx_st = SPU_RX_IDLE;
            end else begin
              st_next.rx_idx = st_reg.rx_idx + 4'h1;
            end
          end
        end
      end
      default: st_next.rx_st = SPU_RX_IDLE;
    endcase
    rx_char   = st_reg.cfg.data8 ? sh_new[7:0] : {1'b0, sh_new[6:0]};
    rx_bad    = !sh_new[nrx - 4'h1] || (has_par && ((st_reg.cfg.data8 ? sh_new[8] : sh_new[7])
                != spu_par_bit(st_reg.cfg.parity, rx_char)));
    flow_char = st_reg.cfg.tx_pace && (rx_char == SPU_XON_CHAR || rx_char == SPU_XOFF_CHAR);
    if (rx_done) begin
      if (rx_bad) begin
        st_next.line_err = 1'b1;
      end
      if (flow_char) begin
        st_next.paused = (rx_char == SPU_XOFF_CHAR);
      end else begin
        if (st_reg.cfg.echo) begin
          st_next.echo_pend = 1'b1;
          st_next.echo_char = rx_char;
        end
        if (st_reg.cfg.route_cmd) begin
          st_next.cmd.valid = 1'b1;
          st_next.cmd.char  = rx_char;
        end else if (st_reg.count == SPU_RX_DEPTH) begin
          st_next.overrun = 1'b1;
        end else begin
          st_next.mem_we = 1'b1;
          st_next.mem_wd = rx_char;
        end
      end
    end
    if (!st_reg.cfg.tx_pace) begin
      st_next.paused = 1'b0;
    end

    // a stored word becomes visible two cycles after its write
    if (st_reg.mem_we) begin
      st_next.wr_ptr = spu_wrap(st_reg.wr_ptr);
    end
    if (pop) begin
      st_next.rd_ptr = spu_wrap(st_reg.rd_ptr);
    end
    st_next.count = st_reg.count + {10'h000, st_reg.wr_done} - {10'h000, pop};
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg     <= SPU_TOP_RST;
      st_reg.cfg <= nv_cfg;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata   = st_reg.rdata;
  assign txd     = st_reg.tx_line;
  assign cfg_out = st_reg.cfg;
  assign cmd     = st_reg.cmd;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_idle_line_high: assert property (st_reg.tx_left == 4'h0 |-> st_reg.tx_line)
    else $error("line not high between frames");
  a_start_bit_low: assert property (tx_go |=> !st_reg.tx_line ##1 !st_reg.tx_line)
    else $error("frame did not open with a low start bit");
  a_frame_length: assert property (tx_go && st_reg.cfg.data8 && st_reg.cfg.stop2
    && st_reg.cfg.parity == SPU_PAR_NONE |=> st_reg.tx_left == 4'hb)
    else $error("wrong bit count for 8 data, no parity, 2 stop");
  a_even_parity: assert property (tx_go && st_reg.cfg.data8
    && st_reg.cfg.parity == SPU_PAR_EVEN |=> st_reg.tx_sh[8] == ^$past(tx_char))
    else $error("even parity bit wrong");
  a_pause_blocks: assert property (st_reg.paused |-> !sw_load)
    else $error("software data sent while paused");
  a_pace_off: assert property (!st_reg.cfg.tx_pace |=> !st_reg.paused)
    else $error("paused with transmit pacing off");
  a_buf_bound: assert property (st_reg.count <= SPU_RX_DEPTH)
    else $error("receive count above capacity");
  a_store_path: assert property (rx_done && !flow_char && !st_reg.cfg.route_cmd
    && st_reg.count < SPU_XOFF_LEVEL |=> st_reg.mem_we ##2 st_reg.count == $past(st_reg.count, 3) + 11'h001)
    else $error("received character not stored");
  a_cmd_unpaced: assert property (st_reg.cfg.route_cmd |-> !want_off)
    else $error("xoff sent while routed to command line");
  a_cmd_route: assert property (rx_done && !flow_char && st_reg.cfg.route_cmd
    |=> st_reg.cmd.valid && st_reg.cmd.char == $past(rx_char) && !st_reg.mem_we)
    else $error("command-routed character misdelivered");
  a_echo_back: assert property (rx_done && !flow_char && st_reg.cfg.echo
    |=> st_reg.echo_pend && st_reg.echo_char == $past(rx_char))
    else $error("received character not queued for echo");
  a_line_err_set: assert property (rx_done && rx_bad |=> st_reg.line_err)
    else $error("bad parity or stop bit not flagged");
  a_cfg_hold: assert property (!(req.wr && req.addr == SPU_ADDR_CFG) |=> $stable(st_reg.cfg))
    else $error("configuration changed without a write");

endmodule
`default_nettype wire

// File: spu_far_end.sv
// Purpose: far-end terminal model for the paced serial port bench
// Assumes: bit time given in clocks; line idles high between frames
// Notes:   send() drives rxd; frames seen on txd come out on got_*
`timescale 1ns/10ps
`default_nettype none
module spu_far_end
  import spu_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        txd,
  input  wire spu_cfg_t    cfg,
  input  wire logic [15:0] bt,
  output var  logic        rxd,
  output var  logic        got_stb,
  output var  logic [7:0]  got_char,
  output var  logic        got_err
);
  // own parity table, kept apart from the design's helper
  function automatic logic par_of(input spu_par_t p, input logic [7:0] d);
    case (p)
      SPU_PAR_ODD:  par_of = ~(^d);
      SPU_PAR_EVEN: par_of = ^d;
      default:      par_of = (p == SPU_PAR_ONE);
    endcase
  endfunction

  initial begin
    rxd = 1'b1;
    got_stb = 1'b0;
    got_char = 8'h00;
    got_err = 1'b0;
  end

  task automatic send(input logic [7:0] d);
    logic [7:0] m;
    m = cfg.data8 ? d : {1'b0, d[6:0]};
    @(posedge clk);
    rxd <= 1'b0;
    repeat (bt) @(posedge clk);
    for (int i = 0; i < (cfg.data8 ? 8 : 7); i++) begin
      rxd <= m[i];
      repeat (bt) @(posedge clk);
    end
    if (cfg.parity != SPU_PAR_NONE) begin
      rxd <= par_of(cfg.parity, m);
      repeat (bt) @(posedge clk);
    end
    rxd <= 1'b1;
    repeat (cfg.stop2 ? 2 * bt : bt) @(posedge clk);
  endtask

  always begin
    logic [7:0] d;
    logic       e;
    @(negedge txd);
    d = 8'h00;
    repeat (bt / 2) @(posedge clk);
    e = txd;
    for (int i = 0; i < (cfg.data8 ? 8 : 7); i++) begin
      repeat (bt) @(posedge clk);
      d[i] = txd;
    end
    if (cfg.parity != SPU_PAR_NONE) begin
      repeat (bt) @(posedge clk);
      e = e | (txd != par_of(cfg.parity, d));
    end
    repeat (bt) @(posedge clk);
    e = e | !txd;
    if (cfg.stop2) begin
      repeat (bt) @(posedge clk);
      e = e | !txd;
    end
    got_char <= d;
    got_err <= e;
    got_stb <= 1'b1;
    @(posedge clk);
    got_stb <= 1'b0;
  end
endmodule
`default_nettype wire

// File: test_serial_port_pacing_uart.sv
// Purpose: self-checking bench of the paced serial port
// Assumes: shortened CLK_HZ so 19200 baud is 80 clocks a bit
// Notes:   retained cfg store modelled by feeding cfg_out back to nv_cfg
`timescale 1ns/10ps
`default_nettype none
module test_serial_port_pacing_uart
  import spu_pkg::*;
;
  localparam int unsigned CLK_HZ = 1600000;
  logic        clk;
  logic        reset;
  spu_req_t    req;
  logic [15:0] rdata;
  logic        rxd;
  logic        txd;
  spu_cfg_t    nv_cfg;
  spu_cfg_t    cfg_out;
  spu_cfg_t    cfg;
  spu_cmd_t    cmd;
  logic [15:0] bt;
  logic        got_stb;
  logic [7:0]  got_char;
  logic        got_err;
  logic        rd_pend;
  int          err_total;
  int          check_count;
  int          seed;
  logic [7:0]  exp_tx[$];
  logic [7:0]  exp_cmd[$];
  logic [15:0] exp_rd[$];

  spu_top #(.CLK_HZ(CLK_HZ)) dut_u (.clk(clk), .reset(reset), .req(req), .rdata(rdata),
    .rxd(rxd), .txd(txd), .nv_cfg(nv_cfg), .cfg_out(cfg_out), .cmd(cmd));
  spu_far_end far_u (.clk(clk), .txd(txd), .cfg(cfg), .bt(bt), .rxd(rxd),
    .got_stb(got_stb), .got_char(got_char), .got_err(got_err));

  always #5 clk = ~clk;
  // retention outside the block: survives resets
  always @(posedge clk) if (!reset) nv_cfg <= cfg_out;

  task automatic wrap_up;
    if (err_total == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
  endtask

  task automatic rd(input logic [1:0] a, input logic [15:0] e);
    exp_rd.push_back(e);
    @(posedge clk);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b0};
  endtask

  task automatic cfg_set(input spu_cfg_t c);
    cfg = c;
    bt = 16'(16 * (CLK_HZ / (SPU_BAUD_HZ[c.baud] * 16)));
    wr(SPU_ADDR_CFG, {4'h0, c});
    rd(SPU_ADDR_CFG, {4'h0, c});
    // a rate change applies at once: the running divider count is compared with the new divisor
    repeat (200) @(posedge clk);
  endtask

  task automatic tx_char(input logic [7:0] c);
    exp_tx.push_back(cfg.data8 ? c : {1'b0, c[6:0]});
    wr(SPU_ADDR_TXDATA, {8'h00, c});
  endtask

  task automatic wait_tx;
    for (int k = 0; k < 40000 && exp_tx.size() > 0; k++) @(posedge clk);
    if (exp_tx.size() > 0) begin
      chk("txd timeout", 16'h0000, 16'h0001);
      wrap_up();
    end else begin
      repeat (20) @(posedge clk);
    end
  endtask

  always @(posedge clk) begin
    if (rd_pend) begin
      chk("rdata", exp_rd[0], rdata);
      void'(exp_rd.pop_front());
    end
    rd_pend <= (req.rd === 1'b1);
    if (got_stb === 1'b1) begin
      chk("txd framing", 16'h0000, {15'h0, got_err});
      if (exp_tx.size() == 0) begin
        chk("unexpected txd char", 16'h0000, {8'h00, got_char});
      end else begin
        chk("txd char", {8'h00, exp_tx[0]}, {8'h00, got_char});
        void'(exp_tx.pop_front());
      end
    end
    if (cmd.valid === 1'b1) begin
      if (exp_cmd.size() == 0) begin
        chk("unexpected cmd", 16'h0000, {8'h00, cmd.char});
      end else begin
        chk("cmd char", {8'h00, exp_cmd[0]}, {8'h00, cmd.char});
        void'(exp_cmd.pop_front());
      end
    end
  end

  initial begin
    repeat (95000) @(posedge clk);
    chk("run timeout", 16'h0000, 16'h0001);
    wrap_up();
  end

  initial begin
    spu_cfg_t   c;
    logic [7:0] c1;
    logic [7:0] c2;
    seed = 15;
    clk = 1'b0;
    reset = 1'b1;
    req = '0;
    rd_pend = 1'b0;
    err_total = 0;
    check_count = 0;
    nv_cfg = spu_cfg_t'(12'h047);
    cfg = nv_cfg;
    bt = 16'd80;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    chk("cfg_out after reset", 16'h0047, {4'h0, cfg_out});
    chk("txd idle", 16'h0001, {15'h0, txd});
    for (int i = 0; i < 10; i++) begin
      c = spu_cfg_t'(12'h000);
      c.parity = spu_par_t'(i % 5);
      c.data8 = (i < 5);
      c.stop2 = (i % 3 == 0);
      c.baud = (i < 5) ? 3'h7 : 3'h6;
      cfg_set(c);
      c1 = 8'($random(seed));
      c2 = 8'($random(seed));
      if (!c.data8) c2[7] = 1'b0;
      fork
        tx_char(c1);
        far_u.send(c2);
      join
      wait_tx();
      rd(SPU_ADDR_STATUS, 16'h0001);
      rd(SPU_ADDR_RXDATA, {8'h00, c2});
      rd(SPU_ADDR_STATUS, 16'h0000);
    end
    // far end now disagrees on parity, so the char arrives flagged
    cfg.parity = SPU_PAR_ONE;
    c1 = 8'($random(seed)) & 8'h7f;
    far_u.send(c1);
    repeat (20) @(posedge clk);
    rd(SPU_ADDR_STATUS, 16'h8001);
    rd(SPU_ADDR_STATUS, 16'h0001);
    rd(SPU_ADDR_RXDATA, {8'h00, c1});
    c = spu_cfg_t'(12'h847);
    cfg_set(c);
    c1 = 8'($random(seed));
    exp_tx.push_back(c1);
    far_u.send(c1);
    wait_tx();
    rd(SPU_ADDR_RXDATA, {8'h00, c1});
    cfg_set(spu_cfg_t'(12'h447));
    c1 = 8'($random(seed));
    c2 = 8'($random(seed));
    exp_cmd.push_back(c1);
    exp_cmd.push_back(c2);
    far_u.send(c1);
    far_u.send(c2);
    repeat (20) @(posedge clk);
    rd(SPU_ADDR_STATUS, 16'h0000);
    chk("cmd drained", 16'h0000, 16'(exp_cmd.size()));
    cfg_set(spu_cfg_t'(12'h247));
    far_u.send(SPU_XOFF_CHAR);
    rd(SPU_ADDR_STATUS, 16'h1000);
    c1 = 8'($random(seed));
    tx_char(c1);
    // holding register full: this write must be dropped
    wr(SPU_ADDR_TXDATA, {8'h00, ~c1});
    rd(SPU_ADDR_STATUS, 16'h1800);
    repeat (2000) @(posedge clk);
    chk("held while paused", 16'h0001, 16'(exp_tx.size()));
    far_u.send(SPU_XON_CHAR);
    wait_tx();
    rd(SPU_ADDR_STATUS, 16'h0000);
    cfg_set(spu_cfg_t'(12'h047));
    far_u.send(SPU_XOFF_CHAR);
    rd(SPU_ADDR_STATUS, 16'h0001);
    rd(SPU_ADDR_RXDATA, {8'h00, SPU_XOFF_CHAR});
    cfg_set(spu_cfg_t'(12'h0a6));
    reset <= 1'b1;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    chk("cfg kept over reset", 16'h00a6, {4'h0, cfg_out});
    repeat (4) @(posedge clk);
    wrap_up();
  end
endmodule
`default_nettype wire
